// ### hw/seedm_map.vh
// register map, command codes and timing constants for the data eeprom
// Operation
// - storage is 128 words of 8 bits, readable and writable.
// - frame is start bit 1, 2-bit opcode, 7-bit address, msb first.
// - serial input sampled on each shift clock rise while select high; the code ignores rises while busy or while read data shifts out.
// - serial output valid only with select high; otherwise reads high.
// - after power-on programming is disabled.
// - erase and write commands ignored unless programming enabled.
// - enable persists until program-disable command or power loss.
// - read shifts out a 0 dummy bit then 8 data bits.
// - read output bit updates on each shift clock rising edge.
// - read works whether programming enabled or disabled.
// - read address increments and wraps while select stays high.
// - enabled erase starts at select fall, internally timed.
// - during busy with select high output low, high when done.
// - enabled write starts at select fall after 8 data bits.
// - word write erases target before programming.
// - erase-all sets every bit of every word to 1.
// - write-all programs the data value into every word.
// - opcode 10 read, 11 erase, 01 write, then address, data.
// - opcode 00 uses top address bits: 11 en, 00 dis, 10 erase_all_cmd, 01 write_all_cmd.
// - control bits: select 4, shift clock 5, in 6, out 7, 0-3 zero.
`ifndef SEEDM_MAP_VH
`define SEEDM_MAP_VH
`define SEEDM_CTRL_ADDR   8'h40
`define SEEDM_BIT_SEL     4
`define SEEDM_BIT_SCK     5
`define SEEDM_BIT_SIN     6
`define SEEDM_BIT_SOUT    7
`define SEEDM_OP_SPECIAL  2'h0
`define SEEDM_OP_WRITE    2'h1
`define SEEDM_OP_READ     2'h2
`define SEEDM_OP_ERASE    2'h3
`define SEEDM_SP_DISABLE  2'h0
`define SEEDM_SP_WRALL    2'h1
`define SEEDM_SP_ERALL    2'h2
`define SEEDM_SP_ENABLE   2'h3
`define SEEDM_HDR_BITS    5'h0a
`define SEEDM_FRAME_BITS  5'h12
`define SEEDM_ERASED      8'hff
`define SEEDM_PROG_TIME_US 2000
`define SEEDM_CLK_MHZ      10
`endif

// ### hw/seedm_top.v
// serial data eeprom behind an 8-bit bit-banged control register
`include "seedm_map.vh"
`default_nettype none
module seedm_top #(
  parameter WORDS      = 128,
  parameter AW         = 7,
  parameter DW         = 8,
  parameter PROG_TICKS = `SEEDM_PROG_TIME_US * `SEEDM_CLK_MHZ
) (
  // clock and reset
  input  wire          sys_clk_i,
  input  wire          resetn_i,
  // core register port
  input  wire [7:0]    reg_addr_i,
  input  wire          reg_wr_i,
  input  wire [7:0]    reg_wdata_i,
  output reg  [7:0]    reg_rdata_o,
  // status
  output reg           busy_o
);

  // control register latches
  reg          sel_q;
  reg          sck_q;
  reg          sin_q;
  // synchronised copies
  reg  [1:0]   sel_s_q;
  reg  [1:0]   sck_s_q;
  reg  [1:0]   sin_s_q;
  reg          sel_d1_q;
  reg          sck_d1_q;
  // frame state
  reg  [17:0]  shift_q;
  reg  [4:0]   cnt_q;
  reg          prog_en_q;
  reg          reading_q;
  reg  [AW-1:0] raddr_q;
  reg  [3:0]   rbit_q;
  reg  [DW-1:0] rword_q;
  reg          dout_q;
  // program engine
  reg  [1:0]   pop_q;
  reg  [AW-1:0] paddr_q;
  reg  [DW-1:0] pdata_q;
  reg  [31:0]  ptimer_q;
  reg  [DW-1:0] mem_q [0:WORDS-1];

  wire sel_v   = sel_s_q[1];
  wire sck_v   = sck_s_q[1];
  wire sin_v   = sin_s_q[1];
  wire sck_re  = sck_v & ~sck_d1_q;
  wire sel_fe  = ~sel_v & sel_d1_q;
  wire hit     = (reg_addr_i == `SEEDM_CTRL_ADDR);
  // opcode of a frame still arriving: one bit short of the header
  wire [1:0] op    = shift_q[7:6];
  // opcode of a finished frame; other lengths under 18 decode as a harmless read
  wire [1:0] op_f  = (cnt_q == `SEEDM_FRAME_BITS) ? shift_q[16:15] :
                     (cnt_q == `SEEDM_HDR_BITS)   ? shift_q[8:7]   :
                                                    `SEEDM_OP_READ;
  wire [AW-1:0] adr_f = shift_q[14:8];
  wire [DW-1:0] dat_f = shift_q[7:0];
  localparam [1:0] P_NONE = 2'h0;
  localparam [1:0] P_WORD = 2'h1;
  localparam [1:0] P_ALL  = 2'h2;

  // register writes and synchronisers
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_q    <= 1'b0;
      sck_q    <= 1'b0;
      sin_q    <= 1'b0;
      sel_s_q  <= 2'h0;
      sck_s_q  <= 2'h0;
      sin_s_q  <= 2'h0;
      sel_d1_q <= 1'b0;
      sck_d1_q <= 1'b0;
    end else begin
      if (reg_wr_i && hit) begin
        sel_q <= reg_wdata_i[`SEEDM_BIT_SEL];
        sck_q <= reg_wdata_i[`SEEDM_BIT_SCK];
        sin_q <= reg_wdata_i[`SEEDM_BIT_SIN];
      end
      sel_s_q  <= {sel_s_q[0], sel_q};
      sck_s_q  <= {sck_s_q[0], sck_q};
      sin_s_q  <= {sin_s_q[0], sin_q};
      sel_d1_q <= sel_v;
      sck_d1_q <= sck_v;
    end
  end

  // frame receiver, read streamer, command launch
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_q   <= 18'h00000;
      cnt_q     <= 5'h00;
      prog_en_q <= 1'b0;
      reading_q <= 1'b0;
      raddr_q   <= {AW{1'b0}};
      rbit_q    <= 4'h0;
      rword_q   <= {DW{1'b0}};
      dout_q    <= 1'b1;
      pop_q     <= P_NONE;
      paddr_q   <= {AW{1'b0}};
      pdata_q   <= {DW{1'b0}};
    end else begin
      if (!sel_v) begin
        reading_q <= 1'b0;
        cnt_q     <= 5'h00;
        shift_q   <= 18'h00000;
      end
      if (sel_fe && !busy_o && cnt_q >= `SEEDM_HDR_BITS) begin
        case (op_f)
          `SEEDM_OP_ERASE: if (prog_en_q) begin
            pop_q   <= P_WORD;
            paddr_q <= (cnt_q == `SEEDM_FRAME_BITS) ? adr_f : shift_q[6:0];
            pdata_q <= `SEEDM_ERASED;
          end
          `SEEDM_OP_WRITE:
            if (prog_en_q && cnt_q == `SEEDM_FRAME_BITS) begin
              pop_q   <= P_WORD;
              paddr_q <= adr_f;
              pdata_q <= dat_f;
            end
          `SEEDM_OP_SPECIAL: begin
            case (cnt_q == `SEEDM_FRAME_BITS ? adr_f[AW-1:AW-2]
                                              : shift_q[6:5])
              `SEEDM_SP_ENABLE:  prog_en_q <= 1'b1;
              `SEEDM_SP_DISABLE: prog_en_q <= 1'b0;
              `SEEDM_SP_ERALL: if (prog_en_q) begin
                pop_q   <= P_ALL;
                pdata_q <= `SEEDM_ERASED;
              end
              `SEEDM_SP_WRALL:
                if (prog_en_q && cnt_q == `SEEDM_FRAME_BITS) begin
                  pop_q   <= P_ALL;
                  pdata_q <= dat_f;
                end
              default: ;
            endcase
          end
          default: ;
        endcase
      end else if (pop_q != P_NONE && ptimer_q == 32'h1) begin
        pop_q <= P_NONE;
      end
      if (sel_v && sck_re && !busy_o) begin
        if (reading_q) begin
          if (rbit_q == 4'h0) begin
            dout_q  <= rword_q[DW-1];
            rword_q <= {rword_q[DW-2:0], 1'b0};
            rbit_q  <= 4'h7;
          end else if (rbit_q == 4'h1) begin
            dout_q  <= rword_q[DW-1];
            rword_q <= mem_q[raddr_q + 1'b1];
            raddr_q <= raddr_q + 1'b1;
            rbit_q  <= 4'h8;
          end else begin
            dout_q  <= rword_q[DW-1];
            rword_q <= {rword_q[DW-2:0], 1'b0};
            rbit_q  <= rbit_q - 4'h1;
          end
        end else if (cnt_q != 5'h00 || sin_v) begin
          shift_q <= {shift_q[16:0], sin_v};
          if (cnt_q < `SEEDM_FRAME_BITS)
            cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `SEEDM_HDR_BITS - 5'h01 &&
              op == `SEEDM_OP_READ) begin
            reading_q <= 1'b1;
            raddr_q   <= {shift_q[5:0], sin_v};
            rword_q   <= mem_q[{shift_q[5:0], sin_v}];
            rbit_q    <= 4'h0;
            dout_q    <= 1'b0;
          end
        end
      end
    end
  end

  // self-timed programming engine
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o   <= 1'b0;
      ptimer_q <= 32'h0;
    end else if (sel_fe && !busy_o && cnt_q >= `SEEDM_HDR_BITS &&
                 prog_en_q && (op_f == `SEEDM_OP_ERASE ||
                 (op_f == `SEEDM_OP_WRITE && cnt_q == `SEEDM_FRAME_BITS) ||
                 (op_f == `SEEDM_OP_SPECIAL && shift_q[6:5] ==
                  `SEEDM_SP_ERALL && cnt_q == `SEEDM_HDR_BITS) ||
                 (op_f == `SEEDM_OP_SPECIAL && cnt_q == `SEEDM_FRAME_BITS &&
                  adr_f[AW-1:AW-2] == `SEEDM_SP_WRALL))) begin
      busy_o   <= 1'b1;
      ptimer_q <= PROG_TICKS;
    end else if (busy_o) begin
      ptimer_q <= ptimer_q - 32'h1;
      if (ptimer_q == 32'h1)
        busy_o <= 1'b0;
    end
  end

  // array storage, committed at the end of the timed cycle
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_word
      always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i)
          mem_q[gi] <= `SEEDM_ERASED;
        else if (busy_o && ptimer_q == 32'h1 &&
                 (pop_q == P_ALL ||
                  (pop_q == P_WORD && paddr_q == gi)))
          mem_q[gi] <= pdata_q;
      end
    end
  endgenerate

  // read-back of the control register
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      reg_rdata_o <= 8'h00;
    else if (!sel_v)
      reg_rdata_o <= {1'b1, sin_q, sck_q, sel_q, 4'h0};
    else if (busy_o && !(ptimer_q == 32'h1))
      reg_rdata_o <= {1'b0, sin_q, sck_q, sel_q, 4'h0};
    else if (reading_q)
      reg_rdata_o <= {dout_q, sin_q, sck_q, sel_q, 4'h0};
    else
      reg_rdata_o <= {1'b1, sin_q, sck_q, sel_q, 4'h0};
  end

endmodule // seedm_top
`default_nettype wire

// ### dv/seedm_chk_checker.sv
// assertions on the data eeprom register port
`default_nettype none
module seedm_chk #(
  parameter int PROG_TICKS = 20000
) (
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  // register port and status
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       busy_o
);
  logic [31:0] bcnt_q;
  logic [2:0]  wpin;
  logic [2:0]  rpin;
  logic        ctl_wr;
  assign wpin = reg_wdata_i[6:4];
  assign rpin = reg_rdata_o[6:4];
  assign ctl_wr = reg_wr_i && reg_addr_i == 8'h40;
  // length of the current busy period
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) bcnt_q <= 32'h0;
    else bcnt_q <= busy_o ? bcnt_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  low_zero_a: assert property (reg_rdata_o[3:0] == 4'h0)
    else $error("low control bits not zero");
  ctrl_echo_a: assert property (ctl_wr |-> ##2 rpin == $past(wpin, 2))
    else $error("control bits not taken");
  ctrl_hold_a: assert property (!ctl_wr && !$past(ctl_wr) |=> $stable(rpin))
    else $error("control bits changed without write");
  idle_out_a: assert property ((!reg_rdata_o[4])[*6] |-> reg_rdata_o[7])
    else $error("serial out low while deselected");
  busy_len_a: assert property ($fell(busy_o) |-> bcnt_q == PROG_TICKS)
    else $error("busy period length wrong");
  busy_max_a: assert property (busy_o |-> bcnt_q < PROG_TICKS)
    else $error("busy period too long");
  busy_start_a: assert property ($rose(busy_o) |->
    !reg_rdata_o[4] && $past(reg_rdata_o[4], 6))
    else $error("busy started without select fall");
  ready_high_a: assert property ($fell(busy_o) && reg_rdata_o[4] |->
    ##[0:6] reg_rdata_o[7])
    else $error("ready not shown after busy");
  busy_low_a: assert property (busy_o && bcnt_q > 8 &&
    bcnt_q < PROG_TICKS - 8 && reg_rdata_o[4] &&
    $past(reg_rdata_o[4], 6) |-> !reg_rdata_o[7])
    else $error("serial out high while busy");
endmodule // seedm_chk
bind seedm_top seedm_chk #(.PROG_TICKS(PROG_TICKS)) u_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .busy_o(busy_o));
`default_nettype wire

// ### dv/seedm_cpu_model.sv
// cpu model bit-banging the eeprom control register
`default_nettype none
module seedm_cpu_model (
  // clock
  input  wire logic       sys_clk_i,
  // register port
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr_o = 8'h40;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one register write, each pin level held four cycles
  task automatic pins(input logic s, input logic k, input logic i);
    @(posedge sys_clk_i) #1;
    reg_wr_o = 1'b1;
    reg_wdata_o = {1'b0, i, k, s, 4'h0};
    @(posedge sys_clk_i) #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~reg_wdata_o;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic sbit(input logic b);
    pins(1'b1, 1'b0, b);
    pins(1'b1, 1'b1, b);
  endtask
  task automatic frame(input logic [17:0] v, input int n);
    pins(1'b1, 1'b0, 1'b0);
    for (int j = n - 1; j >= 0; j--) sbit(v[j]);
    pins(1'b0, 1'b0, 1'b0);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] q,
                    output logic dum);
    logic [9:0] h;
    h = {1'b1, 2'h2, a};
    pins(1'b1, 1'b0, 1'b0);
    for (int j = 9; j >= 0; j--) sbit(h[j]);
    pins(1'b1, 1'b0, 1'b0);
    dum = reg_rdata_i[7];
    for (int j = 0; j < 16; j++) begin
      pins(1'b1, 1'b1, 1'b0);
      pins(1'b1, 1'b0, 1'b0);
      q = {q[14:0], reg_rdata_i[7]};
    end
    pins(1'b0, 1'b0, 1'b0);
  endtask
endmodule // seedm_cpu_model
`default_nettype wire

// ### dv/seedm_top_test.sv
// self-checking bench for the serial data eeprom
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
  err_total++; $display("Error %s expected %h seen %h", nm, e, s); end end
module seedm_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICKS = 40;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  r_addr, r_wdata, r_rdata, d, em [128];
  logic        r_wr, busy, dum;
  logic [15:0] q;
  logic [6:0]  a;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  seedm_top #(.PROG_TICKS(TICKS)) dut (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .reg_addr_i(r_addr), .reg_wr_i(r_wr),
    .reg_wdata_i(r_wdata), .reg_rdata_o(r_rdata), .busy_o(busy));
  seedm_cpu_model cpu (.sys_clk_i(sys_clk_i), .reg_addr_o(r_addr),
    .reg_wr_o(r_wr), .reg_wdata_o(r_wdata), .reg_rdata_i(r_rdata));
  task automatic finish_test();
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [17:0] wf(logic [6:0] ad, logic [7:0] dt);
    return {1'b1, 2'h1, ad, dt};
  endfunction
  task automatic idle();
    for (int i = 0; i < 300 && busy === 1'b1; i++) @(posedge sys_clk_i);
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic go(logic [17:0] v, int n, logic en);
    cpu.frame(v, n);
    repeat (2) @(posedge sys_clk_i);
    #1 `CHK("busy", en, busy)
    idle();
  endtask
  task automatic rd(logic [6:0] ad);
    cpu.rd(ad, q, dum);
    `CHK("dummy", 1'b0, dum)
    `CHK("words", {em[ad], em[ad + 7'h1]}, q)
  endtask
  initial begin
    void'($urandom(13));
    for (int i = 0; i < 128; i++) em[i] = 8'hff;
    a = $urandom;
    repeat (16) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    @(posedge sys_clk_i) #1;
    `CHK("rdata", 8'h80, r_rdata)
    rd(a);
    go(wf(a, 8'h5a), 18, 1'b0);
    rd(a);
    go({8'h0, 10'h260}, 10, 1'b0);
    for (int k = 0; k < 6; k++) begin
      a = (k < 2) ? 7'h7f : $urandom;
      d = $urandom;
      em[a] = d;
      go(wf(a, d), 18, 1'b1);
    end
    rd(7'h7f);
    rd(a);
    em[7'h7f] = 8'hff;
    cpu.frame({8'h0, 3'h7, 7'h7f}, 10);
    cpu.pins(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge sys_clk_i);
    #1 `CHK("busy out", 1'b0, r_rdata[7])
    idle();
    `CHK("ready out", 1'b1, r_rdata[7])
    cpu.pins(1'b0, 1'b0, 1'b0);
    rd(7'h7e);
    d = $urandom;
    go({10'h220, d}, 18, 1'b1);
    for (int i = 0; i < 128; i++) em[i] = d;
    rd(a);
    go({8'h0, 10'h240}, 10, 1'b1);
    for (int i = 0; i < 128; i++) em[i] = 8'hff;
    rd(a ^ 7'h40);
    go({8'h0, 10'h21f}, 10, 1'b0);
    go({8'h0, 3'h7, a}, 10, 1'b0);
    go(wf(a, d), 18, 1'b0);
    rd(a);
    finish_test();
  end
endmodule // seedm_top_test
`default_nettype wire
